// *** test/host_bfm.sv ***
// smbus host model: bus master that clocks the link and pulls sda
`timescale 1ns/1ps
`default_nettype none
module host_bfm (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // idle: both lines released, clock stands high
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  // one bit: data changes mid-low, sampled mid-high
  task automatic bit_x(input logic b, output logic r);
    scl = 1'b0;
    #20 sda_pull = ~b;
    #20 scl = 1'b1;
    #20 r = sda;
    #20;
  endtask
  // start or repeated start: sda falls while scl is high
  task automatic start_c();
    scl = 1'b0;
    #20 sda_pull = 1'b0;
    #20 scl = 1'b1;
    #40 sda_pull = 1'b1;
    #40;
  endtask
  // stop: sda rises while scl is high, then the bus is released
  task automatic stop_c();
    scl = 1'b0;
    #20 sda_pull = 1'b1;
    #20 scl = 1'b1;
    #40 sda_pull = 1'b0;
    #40;
  endtask
  // eight bits then the ack slot; ack_in high releases the line
  task automatic byte_x(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] q, output logic ack_o);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ack_in, ack_o);
  endtask
endmodule
`default_nettype wire

// *** test/mfr_status_readback_responder_tb.sv ***
// self-checking bench for the read-back responder
`timescale 1ns/1ps
`default_nettype none
module mfr_status_readback_responder_tb;
  localparam int HC = 20;  // shortened hour
  logic sys_clk, resetn, scl, pull, sda_oe, sda_o, ready, pwr, alert_n, shutdown;
  logic rem, hic, rng, ih, is, idst, ff;
  logic [7:0] st1, a1;
  logic [7:3] a3;
  logic [7:1] a2;
  logic [15:0] shr, vo, io, ta, tal, tb, tbl, fp, f1, f2, vi, pi;
  logic [1:0] fpr;
  logic [47:0] fw;
  logic [7:0] rb [16];
  wire logic sda = ~((sda_oe & ~sda_o) | pull);  // open drain with pull-up
  int err_total, n_tests;
  mfr_status_readback_responder #(.HOUR_CYCLES(64'(HC))) u_mfr_status_readback_responder (
    .sys_clk(sys_clk), .resetn(resetn), .ce(1'b1), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .remote_on_pin(rem), .oc_hiccup(hic), .value_range_error(rng),
    .unit_status_low_src(st1), .alarm_three_src(a3), .alarm_two_src(a2),
    .alarm_one_src(a1), .share_current_ma(shr), .iso_host_fail(ih), .iso_self_fail(is),
    .iso_destructive(idst), .fault_final(ff), .data_ready(ready), .unit_powered(pwr),
    .vout_val(vo), .iout_val(io), .temp_a(ta), .temp_a_limit(tal), .temp_b(tb),
    .temp_b_limit(tbl), .fan_pct(fp), .fan1_rpm(f1), .fan2_rpm(f2), .fan_present(fpr),
    .vin_val(vi), .pin_val(pi), .fw_revs(fw), .alert_n(alert_n), .shutdown(shutdown));
  host_bfm u_host_bfm (.scl(scl), .sda_pull(pull), .sda(sda));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic final_report();
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) x = {x[6:0], 1'b0} ^ (x[7] ? 8'h07 : 8'h00);
    return x;
  endfunction
  // advance n edges, then step off the edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // command write, then repeated-start read of n bytes, last one nacked
  task automatic txn(input logic [7:0] cmd, input int n);
    logic [7:0] q, c;
    logic a;
    u_host_bfm.start_c();
    u_host_bfm.byte_x(8'h20, 1'b1, q, a);
    chk("addr ack", a, 1'b0);
    u_host_bfm.byte_x(cmd, 1'b1, q, a);
    c = crc(crc(crc(8'h00, 8'h20), cmd), 8'h21);
    if (n > 0) begin
      u_host_bfm.start_c();
      u_host_bfm.byte_x(8'h21, 1'b1, q, a);
      for (int i = 0; i < n; i++) begin
        u_host_bfm.byte_x(8'hFF, i == n - 1, rb[i], a);
        if (i < n - 1) c = crc(c, rb[i]);
      end
    end
    u_host_bfm.stop_c();
    step(1);
    if (n > 0) chk("pec", rb[n-1], c);
  endtask
  // read a reply and compare every byte before the pec
  task automatic rd(input logic [7:0] cmd, input logic [7:0] e [$]);
    txn(cmd, e.size() + 1);
    foreach (e[i]) chk($sformatf("cmd %h byte %0d", cmd, i), rb[i], e[i]);
  endtask
  // write with a wrong pec, then read back an unsupported command
  task automatic bad_cmds();
    logic [7:0] q;
    logic a;
    u_host_bfm.start_c();
    u_host_bfm.byte_x(8'h20, 1'b1, q, a);
    u_host_bfm.byte_x(8'hE0, 1'b1, q, a);
    u_host_bfm.byte_x(8'hFF, 1'b1, q, a);
    chk("pec ack", a, 1'b0);
    u_host_bfm.start_c();
    u_host_bfm.byte_x(8'h21, 1'b1, q, a);
    u_host_bfm.byte_x(8'hFF, 1'b1, q, a);
    u_host_bfm.stop_c();
    step(1);
    chk("unsupported", q, 8'hFF);
  endtask
  // ---------------------------------------------------------------
  // clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #400000;
    err_total++;
    final_report();
  end
  initial begin
    {resetn, rem, hic, rng, ih, is, idst, ff} = '0;
    {ready, pwr} = 2'b11;
    {st1, a1, a3, a2} = {8'h5A, 8'h81, 5'b10100, 7'b0000011};
    {shr, vo, io, ta, tal, tb, tbl} = {16'd7001, 16'h1234, 16'h5678, 16'd50, 16'd100,
                                       16'd80, 16'd90};
    {fp, f1, f2, fpr, vi, pi} = {16'h0037, 16'h0BB8, 16'h0C00, 2'b01, 16'h00E6, 16'h0DAC};
    fw = 48'h0102_0304_0506;
    step(8);
    resetn = 1'b1;
    step(10 * HC + HC / 2);
    {pwr, rem, hic, rng} = 4'b0111;
    step(4);
    rd(8'hD0, {8'h0B, 8'h43, 8'h5A, 8'hA0, 8'h07, 8'h81, 8'h34, 8'h12, 8'h78, 8'h56, 8'h50, 8'h00});
    rd(8'hD1, {8'h43, 8'h5A});
    shr = 16'd7000;
    step(4);
    rd(8'hD2, {8'h03, 8'hA0, 8'h06, 8'h81});
    rd(8'hD3, {8'h06, 8'h37, 8'h00, 8'hB8, 8'h0B, 8'h00, 8'h00});
    rd(8'hD4, {8'h04, 8'hE6, 8'h00, 8'hAC, 8'h0D});
    rd(8'hD5, {8'h06, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06});
    rd(8'hD6, {8'h03, 8'h0A, 8'h00, 8'h00});
    ready = 1'b0;
    rd(8'hD4, {8'h04, 8'hFF, 8'hFF, 8'hFF, 8'hFF});
    ready = 1'b1;
    is = 1'b1;
    step(1);
    is = 1'b0;
    step(4);
    chk("shutdown", shutdown, 1'b0);
    rd(8'hD1, {8'h4B, 8'h5A});
    bad_cmds();
    ff = 1'b1;
    step(1);
    {ff, rng} = 2'b00;
    step(4);
    chk("alert_n", alert_n, 1'b0);
    rd(8'hD1, {8'hEB, 8'h5A});
    txn(8'h03, 0);
    step(4);
    chk("alert_n", alert_n, 1'b1);
    rd(8'hD1, {8'h41, 8'h5A});
    {idst, ih} = 2'b11;
    step(1);
    ih = 1'b0;
    step(4);
    chk("shutdown", shutdown, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire

// *** verilog/mfr_status_readback_responder.sv ***
// smbus target answering manufacturer-specific read-back commands
// Notes on behaviour
// - replies over two bytes use block read
// - block reply starts with count, PEC excluded
// - analog values go low byte first
// - status and alarms readable together or grouped
// - summary: count 11, status, alarms, analogs
// - summary temperature is nearest its shutdown limit
// - unit command returns status two then one
// - status-two bit layout as listed
// - alarm command returns alarm three to one
// - share current above 7 A sets alarm
// - isolation fault from host or self test
// - destructive isolation fault shuts down
// - non-destructive isolation fault only flags
// - fan reply: count 6, percent, two rpms
// - missing fan or unsupported reads zero
// - input reply: count 4, voltage, power
// - firmware reply: count 6, three rev pairs
// - timer reply: count 3, operating hours
// - hours advance in standby and main output
// - data not ready returns all-ones bytes
// - final fault asserts alert, holds until clear
`timescale 1ns/1ps
`default_nettype none
`include "readback_defines.svh"
module mfr_status_readback_responder
  import readback_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR    = 7'h10,
  parameter logic        FAN_CMD_OK  = 1'b1,
  parameter logic [63:0] HOUR_CYCLES = 64'(`HOUR_S) * 64'(`CLK_HZ)
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        remote_on_pin,
  input  wire logic        oc_hiccup,
  input  wire logic        value_range_error,
  input  wire logic [7:0]  unit_status_low_src,
  input  wire logic [7:3]  alarm_three_src,
  input  wire logic [7:1]  alarm_two_src,
  input  wire logic [7:0]  alarm_one_src,
  input  wire logic [15:0] share_current_ma,
  input  wire logic        iso_host_fail,
  input  wire logic        iso_self_fail,
  input  wire logic        iso_destructive,
  input  wire logic        fault_final,
  input  wire logic        data_ready,
  input  wire logic        unit_powered,
  input  wire logic [15:0] vout_val,
  input  wire logic [15:0] iout_val,
  input  wire logic [15:0] temp_a,
  input  wire logic [15:0] temp_a_limit,
  input  wire logic [15:0] temp_b,
  input  wire logic [15:0] temp_b_limit,
  input  wire logic [15:0] fan_pct,
  input  wire logic [15:0] fan1_rpm,
  input  wire logic [15:0] fan2_rpm,
  input  wire logic [1:0]  fan_present,
  input  wire logic [15:0] vin_val,
  input  wire logic [15:0] pin_val,
  input  wire logic [47:0] fw_revs,
  output logic             alert_n,
  output logic             shutdown
);
  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [2:0] pin_s1;          // first stage, read only by pin_s2
  logic [2:0] pin_s2;          // second stage {remote, sda, scl}
  logic       scl_q, sda_q;    // previous settled levels
  logic       scl_rise, scl_fall, start_evt, stop_evt;

  // two-flop synchroniser for all pin inputs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      // bus lines idle high, so no false edge follows reset
      pin_s1 <= 3'h3;
      pin_s2 <= 3'h3;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
    end else if (ce) begin
      pin_s1 <= {remote_on_pin, sda_i, scl_i};
      pin_s2 <= pin_s1;
      scl_q  <= pin_s2[0];
      sda_q  <= pin_s2[1];
    end
  end

  assign scl_rise  = pin_s2[0] & ~scl_q;
  assign scl_fall  = ~pin_s2[0] & scl_q;
  assign start_evt = pin_s2[0] & scl_q & sda_q & ~pin_s2[1];
  assign stop_evt  = pin_s2[0] & scl_q & ~sda_q & pin_s2[1];

  // ---------------------------------------------------------------
  // link sequencer
  // ---------------------------------------------------------------
  link_state_e state_r;          // sequencer state
  logic [3:0]  bit_cnt_r;        // bits seen in current byte
  logic [7:0]  shreg_r;          // receive shifter
  logic [7:0]  cmd_r;            // latched command code
  logic        cmd_ok_r;         // a command byte was written
  logic        ack_pend_r;       // we owe an ack on next ack slot
  logic [3:0]  idx_r;            // reply byte index
  logic        load_r;           // fetch reply byte next cycle
  logic [7:0]  tx_byte_r;        // byte being shifted out
  logic        oe_r;             // pulling sda low
  logic        clear_evt;        // clear-faults command seen
  logic        pec_chk_r;        // check remainder next cycle
  logic        inv_evt;          // read of unsupported command
  logic [7:0]  rx_byte;          // completed receive byte
  logic [7:0]  crc_val;          // running pec remainder
  logic [7:0]  reply_byte;       // byte selected for idx_r
  logic        reply_inv;        // command not supported

  assign rx_byte   = {shreg_r[6:0], pin_s2[1]};
  assign clear_evt = ce & scl_rise & (state_r == ST_CMD) &
                     (bit_cnt_r == `BIT_LAST) & (rx_byte == `CMD_CLEAR);
  assign inv_evt   = ce & load_r & reply_inv;

  // byte framing, addressing and reply sequencing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r    <= ST_IDLE;
      bit_cnt_r  <= 4'h0;
      shreg_r    <= 8'h00;
      cmd_r      <= 8'h00;
      cmd_ok_r   <= 1'b0;
      ack_pend_r <= 1'b0;
      idx_r      <= 4'h0;
      load_r     <= 1'b0;
      pec_chk_r  <= 1'b0;
    end else if (ce) begin
      load_r    <= 1'b0;
      pec_chk_r <= 1'b0;
      if (stop_evt) begin
        // stop ends every transfer
        state_r    <= ST_IDLE;
        ack_pend_r <= 1'b0;
      end else if (start_evt) begin
        // start or repeated start; command survives a repeat
        state_r    <= ST_ADDR;
        bit_cnt_r  <= 4'h0;
        ack_pend_r <= 1'b0;
        if (state_r == ST_IDLE) begin
          cmd_ok_r <= 1'b0;
        end
      end else if (scl_rise && state_r != ST_IDLE && state_r != ST_SKIP) begin
        bit_cnt_r <= (bit_cnt_r == `BIT_ACK) ? 4'h0 : bit_cnt_r + 4'h1;
        if (bit_cnt_r != `BIT_ACK) begin
          shreg_r <= rx_byte;
        end
        if (bit_cnt_r == `BIT_LAST) begin
          case (state_r)
            ST_ADDR: begin
              if (rx_byte[7:1] != DEV_ADDR) begin
                state_r <= ST_SKIP;
              end else if (rx_byte[0] && cmd_ok_r) begin
                // read after command: first reply byte
                state_r    <= ST_TX;
                ack_pend_r <= 1'b1;
                idx_r      <= 4'h0;
                load_r     <= 1'b1;
              end else if (rx_byte[0]) begin
                state_r <= ST_SKIP;
              end else begin
                state_r    <= ST_CMD;
                ack_pend_r <= 1'b1;
              end
            end
            ST_CMD: begin
              cmd_r      <= rx_byte;
              cmd_ok_r   <= 1'b1;
              ack_pend_r <= 1'b1;
              state_r    <= ST_PEC;
            end
            ST_PEC: begin
              // optional pec on the write phase
              ack_pend_r <= 1'b1;
              pec_chk_r  <= 1'b1;
            end
            default: begin
            end
          endcase
        end else if (bit_cnt_r == `BIT_ACK) begin
          if (ack_pend_r) begin
            ack_pend_r <= 1'b0;
          end else if (state_r == ST_TX && pin_s2[1]) begin
            state_r <= ST_SKIP;
          end else if (state_r == ST_TX) begin
            idx_r  <= idx_r + 4'h1;
            load_r <= 1'b1;
          end
        end
      end
    end
  end

  // sda drive: ack slots and reply bits, changed on scl fall
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      oe_r <= 1'b0;
    end else if (ce) begin
      if (stop_evt || start_evt || state_r == ST_SKIP || state_r == ST_IDLE) begin
        oe_r <= 1'b0;
      end else if (scl_fall) begin
        if (bit_cnt_r == `BIT_ACK) begin
          oe_r <= ack_pend_r;
        end else if (state_r == ST_TX) begin
          oe_r <= ~tx_byte_r[3'(`BIT_LAST - bit_cnt_r)];
        end else begin
          oe_r <= 1'b0;
        end
      end
    end
  end

  assign sda_oe = oe_r;
  assign sda_o  = 1'b0;

  logic crc_act;     // bus bits belong to our transaction
  logic crc_hold_r;  // first bit of a byte waits for scl fall
  logic crc_bit_r;   // value of that held bit

  assign crc_act = state_r != ST_IDLE && state_r != ST_SKIP;

  // the clock rise that opens a repeated start or stop is not a bit:
  // hold the first bit of each byte until scl falls, drop it on start/stop
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      crc_hold_r <= 1'b0;
      crc_bit_r  <= 1'b0;
    end else if (ce) begin
      if (start_evt || stop_evt || scl_fall) begin
        crc_hold_r <= 1'b0;
      end else if (scl_rise && crc_act && bit_cnt_r == 4'h0) begin
        crc_hold_r <= 1'b1;
        crc_bit_r  <= pin_s2[1];
      end
    end
  end

  // pec over every bus data bit of our transaction
  smbus_crc8 u_crc (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .ce      (ce),
    .clr     (start_evt && state_r == ST_IDLE),
    .en      ((scl_rise && crc_act && bit_cnt_r != `BIT_ACK && bit_cnt_r != 4'h0) ||
              (scl_fall && crc_hold_r)),
    .din     (scl_fall ? crc_bit_r : pin_s2[1]),
    .crc     (crc_val)
  );

  // ---------------------------------------------------------------
  // status and alarm registers
  // ---------------------------------------------------------------
  logic [7:0] unit_status_high, unit_status_low;
  logic [7:0] alarm_group_three, alarm_group_two, alarm_group_one;
  logic [7:0] st2_live, al3_live, al2_live;
  logic       frozen_r;        // final fault state reached
  logic       pec_err_r, inv_r, iso_r, shutdown_r, alert_n_r;
  logic       iso_evt;

  assign iso_evt  = iso_host_fail | iso_self_fail;
  assign st2_live = {pec_err_r, oc_hiccup, inv_r, 1'b0, iso_r,
                     1'b0, value_range_error, pin_s2[2]};
  assign al3_live = {alarm_three_src, 2'b00, iso_r};
  assign al2_live = {alarm_two_src,
                     share_current_ma > `SHARE_LIMIT_MA};

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pec_err_r <= 1'b0;
      inv_r     <= 1'b0;
      iso_r     <= 1'b0;
    end else if (ce) begin
      pec_err_r <= (pec_chk_r && crc_val != `CRC_INIT) | (pec_err_r & ~clear_evt);
      inv_r     <= inv_evt | (inv_r & ~clear_evt);
      iso_r     <= iso_evt | (iso_r & ~clear_evt);
    end
  end

  // shutdown only for a destructive isolation fault
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shutdown_r <= 1'b0;
    end else if (ce && iso_evt && iso_destructive) begin
      shutdown_r <= 1'b1;
    end
  end

  // live tracking until final state, then held and only added to
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      frozen_r          <= 1'b0;
      alert_n_r         <= 1'b1;
      unit_status_high  <= 8'h00;
      unit_status_low   <= 8'h00;
      alarm_group_three <= 8'h00;
      alarm_group_two   <= 8'h00;
      alarm_group_one   <= 8'h00;
    end else if (ce) begin
      frozen_r  <= fault_final | (frozen_r & ~clear_evt);
      alert_n_r <= ~(fault_final | (frozen_r & ~clear_evt));
      if (frozen_r && !clear_evt) begin
        unit_status_high  <= unit_status_high | st2_live;
        unit_status_low   <= unit_status_low | unit_status_low_src;
        alarm_group_three <= alarm_group_three | al3_live;
        alarm_group_two   <= alarm_group_two | al2_live;
        alarm_group_one   <= alarm_group_one | alarm_one_src;
      end else begin
        unit_status_high  <= st2_live;
        unit_status_low   <= unit_status_low_src;
        alarm_group_three <= al3_live;
        alarm_group_two   <= al2_live;
        alarm_group_one   <= alarm_one_src;
      end
    end
  end

  assign alert_n  = alert_n_r;
  assign shutdown = shutdown_r;

  // ---------------------------------------------------------------
  // operating hours
  // ---------------------------------------------------------------
  logic [63:0] presc_r;        // cycles within current hour
  logic [23:0] hours_r;        // about 1900 years of range
  logic        hour_tick;

  assign hour_tick = (presc_r == HOUR_CYCLES - 64'h1);

  // counts whenever the unit is in standby or main output
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      presc_r <= 64'h0;
      hours_r <= 24'h0;
    end else if (ce && unit_powered) begin
      presc_r <= hour_tick ? 64'h0 : presc_r + 64'h1;
      if (hour_tick) begin
        hours_r <= hours_r + 24'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // reply assembly
  // ---------------------------------------------------------------
  logic [95:0] rdata;          // data bytes, first in top byte
  logic [3:0]  rlen;           // data byte count
  logic        rblk;           // block read format
  logic [3:0]  pos;            // position, 0 is the count byte
  logic [15:0] temp_sel;       // hottest relative to its limit

  // pick the sensor with the smaller margin to shutdown
  assign temp_sel = ((temp_a_limit - temp_a) <= (temp_b_limit - temp_b)) ?
                    temp_a : temp_b;

  // per-command data layout, analog values low byte before high byte
  always_comb begin
    rdata     = 96'h0;
    rlen      = 4'h0;
    rblk      = 1'b1;
    reply_inv = 1'b0;
    case (cmd_r)
      `CMD_SUMMARY: begin
        rlen  = `LEN_SUMMARY;
        rdata = {unit_status_high, unit_status_low, alarm_group_three,
                 alarm_group_two, alarm_group_one,
                 vout_val[7:0], vout_val[15:8], iout_val[7:0], iout_val[15:8],
                 temp_sel[7:0], temp_sel[15:8], 8'h00};
      end
      `CMD_UNIT: begin
        rlen  = `LEN_UNIT;
        rblk  = 1'b0;
        rdata = {unit_status_high, unit_status_low, 80'h0};
      end
      `CMD_ALARM: begin
        rlen  = `LEN_ALARM;
        rdata = {alarm_group_three, alarm_group_two, alarm_group_one, 72'h0};
      end
      `CMD_FAN: begin
        rlen  = `LEN_FAN;
        rdata = {fan_pct[7:0], fan_pct[15:8],
                 fan1_rpm[7:0], fan1_rpm[15:8],
                 fan2_rpm[7:0], fan2_rpm[15:8], 48'h0};
        rdata[95:80] = FAN_CMD_OK ? rdata[95:80] : 16'h0;
        rdata[79:64] = (FAN_CMD_OK && fan_present[0]) ? rdata[79:64] : 16'h0;
        rdata[63:48] = (FAN_CMD_OK && fan_present[1]) ? rdata[63:48] : 16'h0;
      end
      `CMD_INPUT: begin
        rlen  = `LEN_INPUT;
        rdata = {vin_val[7:0], vin_val[15:8], pin_val[7:0], pin_val[15:8], 64'h0};
      end
      `CMD_FWREV: begin
        rlen  = `LEN_FWREV;
        rdata = {fw_revs, 48'h0};
      end
      `CMD_TIMER: begin
        rlen  = `LEN_TIMER;
        rdata = {hours_r[7:0], hours_r[15:8], hours_r[23:16], 72'h0};
      end
      default: begin
        reply_inv = 1'b1;
      end
    endcase
  end

  assign pos = rblk ? idx_r : idx_r + 4'h1;

  // byte at the current position: count, data, pec, then fill
  always_comb begin
    reply_byte = `FILL_BYTE;
    if (reply_inv) begin
      reply_byte = `FILL_BYTE;
    end else if (pos == 4'h0) begin
      reply_byte = {4'h0, rlen};
    end else if (pos <= rlen) begin
      reply_byte = data_ready ? rdata[8'(8'd103 - {pos, 3'b000}) -: 8] :
                   `FILL_BYTE;
    end else if (pos == rlen + 4'h1) begin
      reply_byte = crc_val;
    end
  end

  // capture the reply byte once per slot so it holds for 8 bits
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_byte_r <= `FILL_BYTE;
    end else if (ce && load_r) begin
      tx_byte_r <= reply_byte;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  chk_power_alarm: assert property (
    ce && share_current_ma > `SHARE_LIMIT_MA |=> alarm_group_two[`AL2_PWR])
    else $error("power delivery alarm missing");
  chk_iso_shutdown: assert property (
    ce && iso_evt && iso_destructive |=> shutdown ##1 shutdown)
    else $error("destructive isolation fault did not shut down");
  chk_iso_flag_only: assert property (
    ce && iso_evt && !iso_destructive && !shutdown |=> !shutdown && iso_r)
    else $error("non-destructive isolation fault handled wrongly");
  chk_alert_hold: assert property (
    ce && fault_final ##1 !clear_evt [*2] |-> !alert_n && frozen_r)
    else $error("alert not held after final fault");
  chk_summary_count: assert property (
    load_r && cmd_r == `CMD_SUMMARY && idx_r == 4'h0 && ce
    |=> tx_byte_r == 8'h0B)
    else $error("summary count wrong");
  chk_not_ready_fill: assert property (
    ce && load_r && !data_ready && !reply_inv && idx_r == 4'h1 && rblk
    |=> tx_byte_r == `FILL_BYTE)
    else $error("not-ready byte is not all ones");
  chk_hours_step: assert property (
    ce && unit_powered && hour_tick |=> hours_r == $past(hours_r) + 24'h1)
    else $error("hour counter did not advance");
  chk_unused_zero: assert property (
    unit_status_high[4] == 1'b0 && unit_status_high[2] == 1'b0 &&
    alarm_group_three[2:1] == 2'b00)
    else $error("unused bit reads nonzero");
  chk_pec_flag: assert property (
    ce && pec_chk_r && crc_val != `CRC_INIT |=> ##1 unit_status_high[`ST2_PEC])
    else $error("bad pec not flagged");
endmodule
`default_nettype wire

// *** verilog/readback_defines.svh ***
// constants for the manufacturer-specific read-back responder
`ifndef READBACK_DEFINES_SVH
`define READBACK_DEFINES_SVH
// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define CMD_SUMMARY    8'hD0
`define CMD_UNIT       8'hD1
`define CMD_ALARM      8'hD2
`define CMD_FAN        8'hD3
`define CMD_INPUT      8'hD4
`define CMD_FWREV      8'hD5
`define CMD_TIMER      8'hD6
`define CMD_CLEAR      8'h03
// ---------------------------------------------------------------
// data byte counts per reply
// ---------------------------------------------------------------
`define LEN_SUMMARY    4'hB
`define LEN_UNIT       4'h2
`define LEN_ALARM      4'h3
`define LEN_FAN        4'h6
`define LEN_INPUT      4'h4
`define LEN_FWREV      4'h6
`define LEN_TIMER      4'h3
// ---------------------------------------------------------------
// status-two and alarm field positions
// ---------------------------------------------------------------
`define ST2_PEC        7
`define ST2_OC         6
`define ST2_INV        5
`define ST2_ISO        3
`define ST2_RANGE      1
`define ST2_REMOTE     0
`define AL3_ISO        0
`define AL2_PWR        0
// ---------------------------------------------------------------
// values and timing
// ---------------------------------------------------------------
`define SHARE_LIMIT_MA 16'h1B58
`define FILL_BYTE      8'hFF
`define ZERO_BYTE      8'h00
`define CRC_POLY       8'h07
`define CRC_INIT       8'h00
`define BIT_LAST       4'h7
`define BIT_ACK        4'h8
`define CLK_HZ         125000000
`define HOUR_S         3600
`endif

// *** verilog/readback_pkg.sv ***
// types shared by the read-back responder
package readback_pkg;
  // link sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_ADDR = 6'b00_0010,
    ST_CMD  = 6'b00_0100,
    ST_PEC  = 6'b00_1000,
    ST_TX   = 6'b01_0000,
    ST_SKIP = 6'b10_0000
  } link_state_e;
endpackage

// *** verilog/smbus_crc8.sv ***
// bit-serial smbus crc-8 accumulator
`timescale 1ns/1ps
`default_nettype none
`include "readback_defines.svh"
module smbus_crc8 (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic       din,
  output logic [7:0]      crc
);
  logic [7:0] crc_r;  // running remainder
  logic       fb;     // feedback bit

  assign fb  = crc_r[7] ^ din;
  assign crc = crc_r;

  // shift one bus bit in, msb first
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      crc_r <= `CRC_INIT;
    end else if (ce) begin
      if (clr) begin
        crc_r <= `CRC_INIT;
      end else if (en) begin
        crc_r <= {crc_r[6:0], 1'b0} ^ (fb ? `CRC_POLY : `ZERO_BYTE);
      end
    end
  end
endmodule
`default_nettype wire
